// >>> hdl/sram_port_consts.svh
`ifndef SRAM_PORT_CONSTS_SVH
`define SRAM_PORT_CONSTS_SVH

// Organisation defaults (36-bit: four lanes of nine bits)
`define SP_LANES 4
`define SP_LANE_W 9
`define SP_ADDR_W 20
`define SP_BURST_W 2

// Strap defaults held while in reset, matching the internal pulls
`define SP_ORDER_RST 1'b1
`define SP_FT_RST 1'b1
`define SP_SCD_RST 1'b1
`define SP_ZQ_RST 1'b1
`define SP_SLEEP_RST 1'b0

// Bit positions in the synchronised strap vector
`define SP_STRAP_ORDER 0
`define SP_STRAP_FT 1
`define SP_STRAP_SCD 2
`define SP_STRAP_ZQ 3
`define SP_STRAP_SLEEP 4
`define SP_STRAP_W 5

`endif

// >>> hdl/sram_port_pkg.sv
package sram_port_pkg;
    // Synchronous command seen at a clock edge, one-hot
    typedef enum logic [4:0] {
        CMD_DESELECT = 5'b00001,
        CMD_BEGIN_READ = 5'b00010,
        CMD_BEGIN_DECODED = 5'b00100,
        CMD_CONTINUE = 5'b01000,
        CMD_SUSPEND = 5'b10000
    } cmd_t;
endpackage

// >>> hdl/burst_counter.sv
module burst_counter
    import sram_port_pkg::*;
#(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic load,
    input wire logic step,
    input wire logic linear,
    input wire logic [W-1:0] start,
    output logic [W-1:0] cur,
    output logic [W-1:0] nxt
);
    logic [W-1:0] start_reg;
    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;

    // Start value and step count; the count wraps so the fifth address repeats
    always_ff @(posedge clk) begin
        if (srst) begin
            start_reg <= '0;
            count_reg <= '0;
        end else if (load) begin
            start_reg <= start;
            count_reg <= '0;
        end else if (step) begin
            count_reg <= count_next;
        end
    end

    // Linear adds the step, interleaved flips bits with it
    always_comb begin
        count_next = W'(count_reg + 1'b1);
        cur = linear ? W'(start_reg + count_reg) : (start_reg ^ count_reg);
        nxt = linear ? W'(start_reg + count_next) : (start_reg ^ count_next);
    end
endmodule

// >>> hdl/sync_burst_sram_port.sv
// Functional notes
// - Order strap low linear, high interleaved
// - Output strap low flow-through, high pipelined
// - Open straps default pipeline, single deselect, low drive
// - Drive strap low selects strong drive
// - Sleep high stops accesses, floats outputs
// - Linear burst counts up modulo four
// - Interleaved burst XORs start with step
// - Global write all lanes, else enabled lanes
// - Reads drive every byte lane
// - Writes keep data pins floating
// - Lanes c and d only when four lanes
// - Chip deselected with controller strobe floats pins
// - Processor strobe begins read, ignores writes
// - Controller strobe begins read or write burst
// - Advance low steps counter and accesses
// - Advance high repeats current address
// - Output enable gates drivers asynchronously
// - Dummy reads advance counter like reads
`include "sram_port_consts.svh"
module sync_burst_sram_port
    import sram_port_pkg::*;
#(
    parameter int LANES = `SP_LANES,
    parameter int LANE_W = `SP_LANE_W,
    parameter int ADDR_W = `SP_ADDR_W
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // Mode straps and sleep, asynchronous
    input wire logic BURST_ORDER_SELECT_N,
    input wire logic OUTPUT_REGISTER_BYPASS_N,
    input wire logic DESELECT_DEPTH_SELECT,
    input wire logic DRIVE_STRENGTH_SELECT,
    input wire logic SLEEP_REQUEST,
    // Synchronous command inputs
    input wire logic CHIP_SELECT_N,
    input wire logic PROCESSOR_ADDRESS_STROBE_N,
    input wire logic CONTROLLER_ADDRESS_STROBE_N,
    input wire logic BURST_STEP_N,
    input wire logic [ADDR_W-1:0] ADDR,
    // Write controls
    input wire logic GLOBAL_WRITE_N,
    input wire logic BYTE_WRITE_ENABLE_N,
    input wire logic BYTE_LANE_A_WRITE_N,
    input wire logic BYTE_LANE_B_WRITE_N,
    input wire logic BYTE_LANE_C_WRITE_N,
    input wire logic BYTE_LANE_D_WRITE_N,
    // Output enable, asynchronous
    input wire logic OUTPUT_ENABLE_N,
    // Data pins
    input wire logic [LANES*LANE_W-1:0] DQ_IN,
    output logic [LANES*LANE_W-1:0] DQ_OUT,
    output logic DQ_OE,
    // Array side
    output logic [ADDR_W-1:0] MEM_ADDR,
    output logic MEM_READ,
    output logic [LANES-1:0] MEM_WRITE,
    output logic [LANES*LANE_W-1:0] MEM_WDATA,
    input wire logic [LANES*LANE_W-1:0] MEM_RDATA,
    // Mode status
    output logic STANDBY,
    output logic DRIVE_STRONG,
    output logic DESELECT_DUAL
);
    logic [`SP_STRAP_W-1:0] strap_meta_reg;
    logic [`SP_STRAP_W-1:0] strap_reg;
    logic [`SP_STRAP_W-1:0] strap_raw;
    logic [`SP_STRAP_W-1:0] strap_rst;
    logic linear;
    logic flow;
    logic sleep;
    cmd_t cmd;
    logic [LANES-1:0] lanes_n;
    logic [LANES-1:0] wr_lanes;
    logic active_reg;
    logic access;
    logic load;
    logic step;
    logic [1:0] low_cur;
    logic [1:0] low_nxt;
    logic [1:0] low_sel;
    logic [ADDR_W-3:0] addr_hi_reg;
    logic [ADDR_W-1:0] mem_addr_reg;
    logic mem_read_reg;
    logic [LANES-1:0] mem_write_reg;
    logic [LANES*LANE_W-1:0] mem_wdata_reg;
    logic [LANES*LANE_W-1:0] pipe_data_reg;
    logic pipe_valid_reg;
    logic [LANES*LANE_W-1:0] dq_out_reg;
    logic drive_reg;
    logic float_now;
    logic standby_reg;
    logic drive_strong_reg;
    logic deselect_dual_reg;

    // Straps pass two flops; reset values mirror the pulls on open pins
    assign strap_raw = {SLEEP_REQUEST, DRIVE_STRENGTH_SELECT, DESELECT_DEPTH_SELECT,
                        OUTPUT_REGISTER_BYPASS_N, BURST_ORDER_SELECT_N};
    assign strap_rst = {`SP_SLEEP_RST, `SP_ZQ_RST, `SP_SCD_RST, `SP_FT_RST, `SP_ORDER_RST};
    always_ff @(posedge CLK) begin
        if (SRST) begin
            strap_meta_reg <= strap_rst;
            strap_reg <= strap_rst;
        end else begin
            strap_meta_reg <= strap_raw;
            strap_reg <= strap_meta_reg;
        end
    end
    assign linear = ~strap_reg[`SP_STRAP_ORDER];
    assign flow = ~strap_reg[`SP_STRAP_FT];
    assign sleep = strap_reg[`SP_STRAP_SLEEP];

    // Mode status outputs
    always_ff @(posedge CLK) begin
        if (SRST) begin
            standby_reg <= `SP_SLEEP_RST;
            drive_strong_reg <= ~`SP_ZQ_RST;
            deselect_dual_reg <= ~`SP_SCD_RST;
        end else begin
            standby_reg <= sleep;
            drive_strong_reg <= ~strap_reg[`SP_STRAP_ZQ];
            deselect_dual_reg <= ~strap_reg[`SP_STRAP_SCD];
        end
    end

    // Lanes c and d are dropped in the two-lane organisation
    always_comb begin
        lanes_n = '1;
        lanes_n[0] = BYTE_LANE_A_WRITE_N;
        lanes_n[1] = BYTE_LANE_B_WRITE_N;
        if (LANES > 2) begin
            lanes_n[LANES > 2 ? 2 : 0] = BYTE_LANE_C_WRITE_N;
            lanes_n[LANES > 3 ? 3 : 0] = BYTE_LANE_D_WRITE_N;
        end
    end

    // Global write beats byte write; byte write needs a lane enable
    always_comb begin
        if (!GLOBAL_WRITE_N) begin
            wr_lanes = '1;
        end else if (!BYTE_WRITE_ENABLE_N) begin
            wr_lanes = ~lanes_n;
        end else begin
            wr_lanes = '0;
        end
    end

    // Command decode; processor strobe ignored while chip select is high
    always_comb begin
        if (CHIP_SELECT_N && !CONTROLLER_ADDRESS_STROBE_N) begin
            cmd = CMD_DESELECT;
        end else if (!CHIP_SELECT_N && !PROCESSOR_ADDRESS_STROBE_N) begin
            cmd = CMD_BEGIN_READ;
        end else if (!CONTROLLER_ADDRESS_STROBE_N) begin
            cmd = CMD_BEGIN_DECODED;
        end else if (!BURST_STEP_N) begin
            cmd = CMD_CONTINUE;
        end else begin
            cmd = CMD_SUSPEND;
        end
    end

    // Continue and suspend only touch the array inside a live burst
    always_comb begin
        load = 1'b0;
        step = 1'b0;
        access = 1'b0;
        low_sel = low_cur;
        case (cmd)
            CMD_BEGIN_READ, CMD_BEGIN_DECODED: begin
                load = !sleep;
                access = !sleep;
                low_sel = ADDR[1:0];
            end
            CMD_CONTINUE: begin
                step = !sleep && active_reg;
                access = step;
                low_sel = low_nxt;
            end
            CMD_SUSPEND: begin
                access = !sleep && active_reg;
            end
            default: begin
                access = 1'b0;
            end
        endcase
    end

    burst_counter #(.W(`SP_BURST_W)) u_counter (
        .clk(CLK),
        .srst(SRST),
        .load(load),
        .step(step),
        .linear(linear),
        .start(ADDR[1:0]),
        .cur(low_cur),
        .nxt(low_nxt)
    );

    // Burst liveness and the upper address captured at burst start
    always_ff @(posedge CLK) begin
        if (SRST) begin
            active_reg <= 1'b0;
            addr_hi_reg <= '0;
        end else if (sleep || cmd == CMD_DESELECT) begin
            active_reg <= 1'b0;
        end else if (load) begin
            active_reg <= 1'b1;
            addr_hi_reg <= ADDR[ADDR_W-1:2];
        end
    end

    // Array access issued from the command of this edge
    always_ff @(posedge CLK) begin
        if (SRST) begin
            mem_addr_reg <= '0;
            mem_read_reg <= 1'b0;
            mem_write_reg <= '0;
            mem_wdata_reg <= '0;
        end else begin
            mem_addr_reg <= load ? ADDR : {addr_hi_reg, low_sel};
            if (!access || cmd == CMD_BEGIN_READ) begin
                mem_write_reg <= '0;
                mem_read_reg <= access;
            end else begin
                mem_write_reg <= wr_lanes;
                mem_read_reg <= wr_lanes == '0;
            end
            mem_wdata_reg <= DQ_IN;
        end
    end

    // Writes, deselect and sleep float the pins at once, ahead of any queued read
    assign float_now = sleep || cmd == CMD_DESELECT || (access && cmd != CMD_BEGIN_READ
                       && wr_lanes != '0);

    // Read data path: flow-through skips the pipe stage
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pipe_data_reg <= '0;
            pipe_valid_reg <= 1'b0;
            dq_out_reg <= '0;
            drive_reg <= 1'b0;
        end else begin
            pipe_data_reg <= MEM_RDATA;
            pipe_valid_reg <= mem_read_reg && !float_now;
            dq_out_reg <= flow ? MEM_RDATA : pipe_data_reg;
            if (float_now) begin
                drive_reg <= 1'b0;
            end else begin
                drive_reg <= flow ? mem_read_reg : pipe_valid_reg;
            end
        end
    end

    // Output enable is a pin gate, not sampled; a clocked path would break its async role
    assign DQ_OE = drive_reg && !OUTPUT_ENABLE_N;
    assign DQ_OUT = dq_out_reg;
    assign MEM_ADDR = mem_addr_reg;
    assign MEM_READ = mem_read_reg;
    assign MEM_WRITE = mem_write_reg;
    assign MEM_WDATA = mem_wdata_reg;
    assign STANDBY = standby_reg;
    assign DRIVE_STRONG = drive_strong_reg;
    assign DESELECT_DUAL = deselect_dual_reg;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    property p_deselect;
        cmd == CMD_DESELECT |=> !DQ_OE && !MEM_READ && MEM_WRITE == '0;
    endproperty
    a_deselect: assert property (p_deselect) else $error("deselect did not float");

    property p_begin_read;
        cmd == CMD_BEGIN_READ && !sleep |=> MEM_READ && MEM_WRITE == '0
            && MEM_ADDR == $past(ADDR);
    endproperty
    a_begin_read: assert property (p_begin_read) else $error("begin read wrong");

    property p_begin_write;
        cmd == CMD_BEGIN_DECODED && !sleep && wr_lanes != '0 |=> MEM_WRITE == $past(wr_lanes)
            && !MEM_READ && MEM_ADDR == $past(ADDR);
    endproperty
    a_begin_write: assert property (p_begin_write) else $error("begin write wrong");

    property p_write_float;
        MEM_WRITE != '0 |-> !DQ_OE;
    endproperty
    a_write_float: assert property (p_write_float) else $error("pins driven in write");

    property p_global;
        access && cmd != CMD_BEGIN_READ && !GLOBAL_WRITE_N |=> MEM_WRITE == '1;
    endproperty
    a_global: assert property (p_global) else $error("global write missed lanes");

    property p_upper_hold;
        cmd == CMD_CONTINUE && access ##1 cmd == CMD_CONTINUE && access
            |=> MEM_ADDR[ADDR_W-1:2] == $past(MEM_ADDR[ADDR_W-1:2], 1);
    endproperty
    a_upper_hold: assert property (p_upper_hold) else $error("upper address moved");

    property p_linear;
        step && linear && $past(access) |=> MEM_ADDR[1:0] == 2'($past(MEM_ADDR[1:0]) + 2'h1);
    endproperty
    a_linear: assert property (p_linear) else $error("linear step wrong");

    property p_interleave;
        load && !linear ##1 step && !linear |=> MEM_ADDR[1:0] == ($past(ADDR[1:0], 2) ^ 2'h1);
    endproperty
    a_interleave: assert property (p_interleave) else $error("interleave step wrong");

    property p_oe;
        OUTPUT_ENABLE_N |-> !DQ_OE;
    endproperty
    a_oe: assert property (p_oe) else $error("drivers on with enable high");

    property p_suspend;
        cmd == CMD_SUSPEND && access |=> MEM_ADDR[1:0] == $past(low_cur);
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend moved address");

    property p_dummy;
        step && OUTPUT_ENABLE_N && wr_lanes == '0 |=> MEM_READ && !DQ_OE;
    endproperty
    a_dummy: assert property (p_dummy) else $error("dummy read lost");

    c_burst_four: cover property (load ##1 step ##1 step ##1 step);
    c_flow_read: cover property (flow && MEM_READ ##1 DQ_OE);
    c_pipe_read: cover property (!flow && MEM_READ ##2 DQ_OE);
    c_read_to_write: cover property (MEM_READ && OUTPUT_ENABLE_N ##1 MEM_WRITE != '0);
endmodule

// >>> bench/sram_array_model.sv
module sram_array_model (
    // Clock
    input wire logic clk,
    // Array access from the port
    input wire logic [19:0] addr,
    input wire logic rd,
    input wire logic [3:0] wr,
    input wire logic [35:0] wdata,
    output logic [35:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [35:0] mem [16];
    // Outside a read the data is inverted, so stale values never match
    assign rdata = rd ? mem[addr[3:0]] : ~mem[addr[3:0]];
    // Lane writes, lane 0 in the low bits
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (wr[i]) begin
                mem[addr[3:0]][i*9 +: 9] <= wdata[i*9 +: 9];
            end
        end
    end
endmodule

// >>> bench/test_sync_burst_sram_port.sv
module test_sync_burst_sram_port
    import sram_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] PRD = 4'h3;
    localparam logic [3:0] CBG = 4'h5;
    localparam logic [3:0] CON = 4'hE;
    localparam logic [3:0] SUS = 4'hF;
    localparam logic [3:0] DES = 4'hD;
    localparam logic [5:0] RD = 6'h3F;
    localparam logic [5:0] GWR = 6'h1F;
    logic clk, srst, ord, ft, deselect_depth_select, drv, slp, cs, pa, ca, burst_step_n, gw, bw, la, lb, lc, ld, oe_n;
    logic [19:0] addr, maddr;
    logic [35:0] dq_in, dq_out, mwd, mrdata, d;
    logic dq_oe, mrd, stb, dstr, ddual;
    logic [3:0] mwr, e4;
    logic [1:0] s, e;
    logic [5:0] wt [6] = '{6'h00, 6'h1F, 6'h25, 6'h2F, 6'h30, 6'h20};
    int n_fail = 0;
    int checks = 0;

    sync_burst_sram_port i_sync_burst_sram_port (
        .CLK(clk), .SRST(srst), .BURST_ORDER_SELECT_N(ord), .OUTPUT_REGISTER_BYPASS_N(ft),
        .DESELECT_DEPTH_SELECT(deselect_depth_select), .DRIVE_STRENGTH_SELECT(drv), .SLEEP_REQUEST(slp),
        .CHIP_SELECT_N(cs), .PROCESSOR_ADDRESS_STROBE_N(pa), .CONTROLLER_ADDRESS_STROBE_N(ca),
        .BURST_STEP_N(burst_step_n), .ADDR(addr), .GLOBAL_WRITE_N(gw), .BYTE_WRITE_ENABLE_N(bw),
        .BYTE_LANE_A_WRITE_N(la), .BYTE_LANE_B_WRITE_N(lb), .BYTE_LANE_C_WRITE_N(lc),
        .BYTE_LANE_D_WRITE_N(ld), .OUTPUT_ENABLE_N(oe_n), .DQ_IN(dq_in), .DQ_OUT(dq_out),
        .DQ_OE(dq_oe), .MEM_ADDR(maddr), .MEM_READ(mrd), .MEM_WRITE(mwr), .MEM_WDATA(mwd),
        .MEM_RDATA(mrdata), .STANDBY(stb), .DRIVE_STRONG(dstr), .DESELECT_DUAL(ddual));

    sram_array_model i_sram_array_model (
        .clk(clk), .addr(maddr), .rd(mrd), .wr(mwr), .wdata(mwd), .rdata(mrdata));

    // Free-running clock, 8 ns
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic ck(input logic [35:0] g, input logic [35:0] x);
        checks++;
        if (g !== x) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    // One command per edge; entered and left at a falling edge
    task automatic cmd(input logic [3:0] k, input logic [5:0] w, input logic [19:0] a);
        {cs, pa, ca, burst_step_n} = k;
        {gw, bw, la, lb, lc, ld} = w;
        addr = a;
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic close_out;
        $display("Checks %0d, failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hang guard, far beyond the fewer than a hundred cycles of the run
    initial begin
        #20000;
        n_fail++;
        close_out;
    end

    initial begin
        {srst, ord, ft, deselect_depth_select, drv, slp, oe_n} = 7'h4C;
        {cs, pa, ca, burst_step_n} = SUS;
        {gw, bw, la, lb, lc, ld} = RD;
        addr = 20'h0;
        dq_in = 36'h0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        // Deselect and drive straps left at their pull levels, then driven low
        idle(3);
        ck(stb, 0);
        ck(dstr, 0);
        ck(ddual, 0);
        {deselect_depth_select, drv} = 2'h0;
        idle(3);
        ck(dstr, 1);
        ck(ddual, 1);
        // Full wrap of the burst counter in both orders
        for (int o = 0; o < 2; o++) begin
            ord = o[0];
            idle(3);
            s = o[0] ? 2'h2 : 2'h1;
            cmd(o[0] ? CBG : PRD, RD, {18'h2AB35, s});
            ck(maddr, {18'h2AB35, s});
            for (int k = 1; k < 5; k++) begin
                cmd(o[0] ? 4'hA : CON, RD, 20'h0);
                e = o[0] ? s ^ k[1:0] : s + k[1:0];
                ck(maddr, {18'h2AB35, e});
                ck(mrd, 1);
            end
            cmd(SUS, RD, 20'h0);
            ck(maddr, {18'h2AB35, s});
        end
        // Processor strobe ignores the write inputs
        cmd(PRD, GWR, 20'h0);
        ck(mrd, 1);
        ck(mwr, 0);
        // Write decode table through the controller strobe
        foreach (wt[i]) begin
            dq_in = 36'h9A5C3E17B ^ 36'(i);
            e4 = !wt[i][5] ? 4'hF : (!wt[i][4] ? ~{wt[i][0], wt[i][1], wt[i][2], wt[i][3]} : 4'h0);
            cmd(CBG, wt[i], 20'(i));
            ck(mwr, e4);
            ck(mrd, e4 == 4'h0);
            if (e4 != 4'h0) begin
                ck(dq_oe, 0);
                ck(mwd, dq_in);
            end
        end
        // Flow-through read, then asynchronous output disable
        d = 36'h987654321;
        dq_in = d;
        cmd(CBG, GWR, 20'h00005);
        dq_in = ~d;
        cmd(PRD, RD, 20'h00005);
        ck(mrd, 1);
        cmd(SUS, RD, 20'h0);
        ck(dq_out, d);
        ck(dq_oe, 1);
        oe_n = 1'b1;
        #1;
        ck(dq_oe, 0);
        // Dummy reads step the counter, then a write with no deselect
        cmd(PRD, RD, 20'h00004);
        cmd(CON, RD, 20'h0);
        ck(maddr, 20'h00005);
        ck(dq_oe, 0);
        cmd(CBG, GWR, 20'h00006);
        ck(mwr, 4'hF);
        ck(dq_oe, 0);
        oe_n = 1'b0;
        // Pipelined read after a deselect
        ft = 1'b1;
        cmd(DES, RD, 20'h0);
        ck(dq_oe, 0);
        ck(mrd, 0);
        idle(2);
        cmd(CON, RD, 20'h0);
        ck(mrd, 0);
        cmd(PRD, RD, 20'h00005);
        cmd(SUS, RD, 20'h0);
        ck(dq_oe, 0);
        cmd(SUS, RD, 20'h0);
        ck(dq_out, d);
        ck(dq_oe, 1);
        // Sleep refuses accesses
        slp = 1'b1;
        idle(3);
        ck(stb, 1);
        cmd(PRD, RD, 20'h00005);
        ck(mrd, 0);
        ck(dq_oe, 0);
        slp = 1'b0;
        idle(3);
        ck(stb, 0);
        close_out;
    end
endmodule
